// ---- hw/dsm_pkg.sv ----
`default_nettype none
package dsm_pkg;
    // Register byte offsets
    localparam logic [3:0] REG_STATUS  = 4'h0;
    localparam logic [3:0] REG_CTRL    = 4'h4;
    localparam logic [3:0] REG_VIEW    = 4'h8;
    localparam logic [3:0] REG_DISPLAY = 4'hc;
    localparam logic [1:0] CTRL_SCOPE_RST = 2'h0;
    localparam logic [1:0] SCOPE_FULL     = 2'h2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Status word bit positions
    localparam int ST_FWD  = 0;
    localparam int ST_REV  = 1;
    localparam int ST_DCB  = 2;
    localparam int ST_SHUT = 3;
    localparam int ST_UV   = 5;
    localparam int ST_VREG = 7;
    localparam int ST_ILIM = 8;
    localparam int ST_ACC  = 9;
    localparam int ST_DEC  = 10;
    localparam int ST_ALM  = 11;
    localparam int ST_LINK = 12;
    localparam int ST_BUSY = 15;

    // Menus and items
    localparam logic [2:0] MENU_DRIVE = 3'h3;
    localparam logic [2:0] MENU_IO    = 3'h4;
    localparam logic [2:0] MENU_LAST  = 3'h7;
    localparam logic [3:0] DRV_ITEM_LAST = 4'hb;
    localparam logic [3:0] IO_ITEM_LAST  = 4'h4;
    localparam logic [3:0] ITEM_STATUS   = 4'h7;
    localparam logic [3:0] ITEM_IO_TERM  = 4'h0;
    localparam logic [3:0] ITEM_IO_LINK  = 4'h1;
    localparam logic [3:0] ITEM_IO_VOLT  = 4'h2;
    localparam logic [3:0] ITEM_IO_CURR  = 4'h3;
    localparam logic [3:0] ITEM_IO_METER = 4'h4;

    // Segment glyphs, bit order {dp,g,f,e,d,c,b,a}
    localparam logic [7:0] SEG_BLANK = 8'h00;
    localparam logic [7:0] SEG_UNDER = 8'h08;
    localparam logic [7:0] SEG_DP    = 8'h80;

    typedef enum logic [1:0] {
        LVL_MENU  = 2'b00,
        LVL_LIST  = 2'b01,
        LVL_VALUE = 2'b10
    } dsm_level_t;

    typedef struct packed {
        logic busy;
        logic remote_link_control;
        logic fault_flag;
        logic slowing_down;
        logic speeding_up;
        logic current_limiting;
        logic voltage_regulating;
        logic bus_voltage_ok;
        logic output_shut_down;
        logic dc_braking_active;
        logic running_backward;
        logic running_forward;
    } dsm_flags_t;

    typedef struct packed {
        logic up;
        logic down;
        logic func_data;
        logic program_back_key;
    } dsm_keys_t;

    typedef struct packed {
        logic       relay_30;
        logic       y1_out;
        logic [2:0] link_cmds;
        logic [4:0] din;
    } dsm_terms_t;

    function automatic logic [7:0] hex_glyph(input logic [3:0] v);
        case (v)
            4'h0: hex_glyph = 8'h3f;
            4'h1: hex_glyph = 8'h06;
            4'h2: hex_glyph = 8'h5b;
            4'h3: hex_glyph = 8'h4f;
            4'h4: hex_glyph = 8'h66;
            4'h5: hex_glyph = 8'h6d;
            4'h6: hex_glyph = 8'h7d;
            4'h7: hex_glyph = 8'h07;
            4'h8: hex_glyph = 8'h7f;
            4'h9: hex_glyph = 8'h6f;
            4'ha: hex_glyph = 8'h77;
            4'hb: hex_glyph = 8'h7c;
            4'hc: hex_glyph = 8'h39;
            4'hd: hex_glyph = 8'h5e;
            4'he: hex_glyph = 8'h79;
            default: hex_glyph = 8'h71;
        endcase
    endfunction : hex_glyph
endpackage : dsm_pkg
`default_nettype wire

// ---- hw/dsm_axil_slave.sv ----
`default_nettype none
module dsm_axil_slave (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [3:0]  s_awaddr_i,
    input  wire logic        s_awvalid_i,
    output logic             s_awready_o,
    input  wire logic [31:0] s_wdata_i,
    input  wire logic [3:0]  s_wstrb_i,
    input  wire logic        s_wvalid_i,
    output logic             s_wready_o,
    output logic [1:0]       s_bresp_o,
    output logic             s_bvalid_o,
    input  wire logic        s_bready_i,
    input  wire logic [3:0]  s_araddr_i,
    input  wire logic        s_arvalid_i,
    output logic             s_arready_o,
    output logic [31:0]      s_rdata_o,
    output logic [1:0]       s_rresp_o,
    output logic             s_rvalid_o,
    input  wire logic        s_rready_i,
    output logic             wr_en_o,
    output logic [3:0]       wr_addr_o,
    output logic [31:0]      wr_data_o,
    output logic [3:0]       wr_strb_o,
    input  wire logic        wr_ok_i,
    output logic [3:0]       rd_addr_o,
    input  wire logic [31:0] rd_data_i,
    input  wire logic        rd_ok_i
);
    logic        aw_have_q;
    logic        w_have_q;
    logic [3:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        aw_fire;
    logic        w_fire;

    // Address and data are taken in either order and held until both are in
    assign s_awready_o = !aw_have_q && !s_bvalid_o;
    assign s_wready_o  = !w_have_q && !s_bvalid_o;
    assign aw_fire     = s_awvalid_i && s_awready_o;
    assign w_fire      = s_wvalid_i && s_wready_o;
    assign wr_en_o     = (aw_have_q || aw_fire) && (w_have_q || w_fire);
    assign wr_addr_o   = aw_have_q ? awaddr_q : s_awaddr_i;
    assign wr_data_o   = w_have_q ? wdata_q : s_wdata_i;
    assign wr_strb_o   = w_have_q ? wstrb_q : s_wstrb_i;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 4'h0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
        end else begin
            if (wr_en_o) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end else begin
                if (aw_fire) begin
                    aw_have_q <= 1'b1;
                    awaddr_q  <= s_awaddr_i;
                end
                if (w_fire) begin
                    w_have_q <= 1'b1;
                    wdata_q  <= s_wdata_i;
                    wstrb_q  <= s_wstrb_i;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_bvalid_o <= 1'b0;
            s_bresp_o  <= dsm_pkg::RESP_OKAY;
        end else if (wr_en_o) begin
            s_bvalid_o <= 1'b1;
            s_bresp_o  <= wr_ok_i ? dsm_pkg::RESP_OKAY : dsm_pkg::RESP_SLVERR;
        end else if (s_bready_i) begin
            s_bvalid_o <= 1'b0;
        end
    end

    // Read data is captured at the address handshake, so it is one cycle old
    assign s_arready_o = !s_rvalid_o;
    assign rd_addr_o   = s_araddr_i;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_rvalid_o <= 1'b0;
            s_rdata_o  <= 32'h0;
            s_rresp_o  <= dsm_pkg::RESP_OKAY;
        end else if (s_arvalid_i && s_arready_o) begin
            s_rvalid_o <= 1'b1;
            s_rdata_o  <= rd_ok_i ? rd_data_i : 32'h0;
            s_rresp_o  <= rd_ok_i ? dsm_pkg::RESP_OKAY : dsm_pkg::RESP_SLVERR;
        end else if (s_rready_i) begin
            s_rvalid_o <= 1'b0;
        end
    end
endmodule : dsm_axil_slave
`default_nettype wire

// ---- hw/dsm_menu_nav.sv ----
`default_nettype none
module dsm_menu_nav (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    input  wire dsm_pkg::dsm_keys_t keys_i,
    input  wire logic [1:0]        menu_scope_setting_i,
    output dsm_pkg::dsm_level_t    level_o,
    output logic [2:0]             menu_o,
    output logic [3:0]             item_o
);
    logic [3:0] item_last;
    logic       has_list;

    assign has_list  = (menu_o == dsm_pkg::MENU_DRIVE) || (menu_o == dsm_pkg::MENU_IO);
    assign item_last = (menu_o == dsm_pkg::MENU_IO) ? dsm_pkg::IO_ITEM_LAST
                                                    : dsm_pkg::DRV_ITEM_LAST;

    // In the list and value levels the back key wins over the other keys when pressed together; the menu level ignores it
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_o <= dsm_pkg::LVL_MENU;
            menu_o  <= dsm_pkg::MENU_DRIVE;
            item_o  <= 4'h0;
        end else begin
            case (level_o)
                dsm_pkg::LVL_MENU: begin
                    if (keys_i.func_data && has_list) begin
                        level_o <= dsm_pkg::LVL_LIST;
                        item_o  <= 4'h0;
                    end else if (menu_scope_setting_i == dsm_pkg::SCOPE_FULL) begin
                        if (keys_i.up) begin
                            menu_o <= (menu_o == dsm_pkg::MENU_LAST) ? 3'h0 : menu_o + 3'h1;
                        end else if (keys_i.down) begin
                            menu_o <= (menu_o == 3'h0) ? dsm_pkg::MENU_LAST : menu_o - 3'h1;
                        end
                    end
                end
                dsm_pkg::LVL_LIST: begin
                    if (keys_i.program_back_key) begin
                        level_o <= dsm_pkg::LVL_MENU;
                    end else if (keys_i.func_data) begin
                        level_o <= dsm_pkg::LVL_VALUE;
                    end else if (keys_i.up) begin
                        item_o <= (item_o == item_last) ? 4'h0 : item_o + 4'h1;
                    end else if (keys_i.down) begin
                        item_o <= (item_o == 4'h0) ? item_last : item_o - 4'h1;
                    end
                end
                dsm_pkg::LVL_VALUE: begin
                    if (keys_i.program_back_key) begin
                        level_o <= dsm_pkg::LVL_LIST;
                    end
                end
                default: begin
                    level_o <= dsm_pkg::LVL_MENU;
                end
            endcase
        end
    end
endmodule : dsm_menu_nav
`default_nettype wire

// ---- hw/dsm_monitor_top.sv ----
`default_nettype none
module dsm_monitor_top (
    input  wire logic               sys_clk_i,
    input  wire logic               rst_n_i,
    // Drive condition flags and terminal readings
    input  wire dsm_pkg::dsm_flags_t flags_i,
    input  wire dsm_pkg::dsm_terms_t terms_i,
    input  wire dsm_pkg::dsm_terms_t link_terms_i,
    input  wire logic [15:0]        drive_item_value_i,
    input  wire logic [15:0]        analog_voltage_input_i,
    input  wire logic [15:0]        analog_current_input_i,
    input  wire logic [15:0]        analog_meter_output_i,
    output logic [3:0]              drive_item_sel_o,
    // Operator keys, one-cycle pulses
    input  wire dsm_pkg::dsm_keys_t keys_i,
    // Digits, [31:24] leftmost, segments {dp,g,f,e,d,c,b,a}, high lights
    output logic [31:0]             seg_o,
    // AXI4-Lite slave
    input  wire logic [3:0]         s_awaddr_i,
    input  wire logic               s_awvalid_i,
    output logic                    s_awready_o,
    input  wire logic [31:0]        s_wdata_i,
    input  wire logic [3:0]         s_wstrb_i,
    input  wire logic               s_wvalid_i,
    output logic                    s_wready_o,
    output logic [1:0]              s_bresp_o,
    output logic                    s_bvalid_o,
    input  wire logic               s_bready_i,
    input  wire logic [3:0]         s_araddr_i,
    input  wire logic               s_arvalid_i,
    output logic                    s_arready_o,
    output logic [31:0]             s_rdata_o,
    output logic [1:0]              s_rresp_o,
    output logic                    s_rvalid_o,
    input  wire logic               s_rready_i
);
    logic                wr_en;
    logic [3:0]          wr_addr;
    logic [31:0]         wr_data;
    logic [3:0]          wr_strb;
    logic                wr_ok;
    logic [3:0]          rd_addr;
    logic [31:0]         rd_data;
    logic                rd_ok;
    logic [1:0]          menu_scope_setting_q;
    logic [15:0]         running_status_word_q;
    logic [15:0]         status_d;
    logic [31:0]         seg_d;
    dsm_pkg::dsm_level_t level;
    logic [2:0]          menu;
    logic [3:0]          item;

    // Register bus
    dsm_axil_slave u_bus (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .s_awaddr_i  (s_awaddr_i),
        .s_awvalid_i (s_awvalid_i),
        .s_awready_o (s_awready_o),
        .s_wdata_i   (s_wdata_i),
        .s_wstrb_i   (s_wstrb_i),
        .s_wvalid_i  (s_wvalid_i),
        .s_wready_o  (s_wready_o),
        .s_bresp_o   (s_bresp_o),
        .s_bvalid_o  (s_bvalid_o),
        .s_bready_i  (s_bready_i),
        .s_araddr_i  (s_araddr_i),
        .s_arvalid_i (s_arvalid_i),
        .s_arready_o (s_arready_o),
        .s_rdata_o   (s_rdata_o),
        .s_rresp_o   (s_rresp_o),
        .s_rvalid_o  (s_rvalid_o),
        .s_rready_i  (s_rready_i),
        .wr_en_o     (wr_en),
        .wr_addr_o   (wr_addr),
        .wr_data_o   (wr_data),
        .wr_strb_o   (wr_strb),
        .wr_ok_i     (wr_ok),
        .rd_addr_o   (rd_addr),
        .rd_data_i   (rd_data),
        .rd_ok_i     (rd_ok)
    );

    // Read-only registers accept writes with an error so software notices
    assign wr_ok = (wr_addr == dsm_pkg::REG_CTRL);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            menu_scope_setting_q <= dsm_pkg::CTRL_SCOPE_RST;
        end else if (wr_en && wr_ok && wr_strb[0]) begin
            menu_scope_setting_q <= wr_data[1:0];
        end
    end

    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h0;
        case (rd_addr)
            dsm_pkg::REG_STATUS:  rd_data = {16'h0, running_status_word_q};
            dsm_pkg::REG_CTRL:    rd_data = {30'h0, menu_scope_setting_q};
            dsm_pkg::REG_VIEW:    rd_data = {22'h0, level, 1'b0, menu, item};
            dsm_pkg::REG_DISPLAY: rd_data = seg_o;
            default:              rd_ok   = 1'b0;
        endcase
    end

    // Running status word
    always_comb begin
        status_d                   = 16'h0;
        status_d[dsm_pkg::ST_BUSY] = flags_i.busy;
        status_d[dsm_pkg::ST_LINK] = flags_i.remote_link_control;
        status_d[dsm_pkg::ST_ALM]  = flags_i.fault_flag;
        status_d[dsm_pkg::ST_DEC]  = flags_i.slowing_down;
        status_d[dsm_pkg::ST_ACC]  = flags_i.speeding_up;
        status_d[dsm_pkg::ST_ILIM] = flags_i.current_limiting;
        status_d[dsm_pkg::ST_VREG] = flags_i.voltage_regulating;
        status_d[dsm_pkg::ST_UV]   = flags_i.bus_voltage_ok;
        status_d[dsm_pkg::ST_SHUT] = flags_i.output_shut_down;
        status_d[dsm_pkg::ST_DCB]  = flags_i.dc_braking_active;
        status_d[dsm_pkg::ST_REV]  = flags_i.running_backward;
        status_d[dsm_pkg::ST_FWD]  = flags_i.running_forward;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            running_status_word_q <= 16'h0;
        end else begin
            running_status_word_q <= status_d;
        end
    end

    // Key navigation
    dsm_menu_nav u_nav (
        .sys_clk_i            (sys_clk_i),
        .rst_n_i              (rst_n_i),
        .keys_i               (keys_i),
        .menu_scope_setting_i (menu_scope_setting_q),
        .level_o              (level),
        .menu_o               (menu),
        .item_o               (item)
    );

    // Drive items other than the status word come from the drive core
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_item_sel_o <= 4'h0;
        end else begin
            drive_item_sel_o <= item;
        end
    end

    function automatic logic [31:0] hex_word(input logic [15:0] v);
        hex_word = {dsm_pkg::hex_glyph(v[15:12]), dsm_pkg::hex_glyph(v[11:8]),
                    dsm_pkg::hex_glyph(v[7:4]), dsm_pkg::hex_glyph(v[3:0])};
    endfunction : hex_word

    // Terminal view lights one segment per closed terminal
    function automatic logic [31:0] term_word(input dsm_pkg::dsm_terms_t t);
        term_word = {7'h0, t.relay_30, 7'h0, t.y1_out,
                     t.link_cmds[2], t.link_cmds[1], t.link_cmds[0], 5'h0,
                     3'h0, t.din};
    endfunction : term_word

    // Display composition
    always_comb begin
        seg_d = {dsm_pkg::SEG_BLANK, dsm_pkg::SEG_BLANK,
                 dsm_pkg::SEG_BLANK, dsm_pkg::SEG_BLANK};
        case (level)
            dsm_pkg::LVL_MENU: begin
                seg_d[31:24] = dsm_pkg::hex_glyph({1'b0, menu}) | dsm_pkg::SEG_DP;
            end
            dsm_pkg::LVL_LIST: begin
                seg_d = {dsm_pkg::hex_glyph({1'b0, menu}), dsm_pkg::SEG_UNDER,
                         dsm_pkg::hex_glyph(item / 4'ha),
                         dsm_pkg::hex_glyph(item % 4'ha)};
            end
            dsm_pkg::LVL_VALUE: begin
                if (menu == dsm_pkg::MENU_IO) begin
                    case (item)
                        dsm_pkg::ITEM_IO_TERM:  seg_d = term_word(terms_i);
                        dsm_pkg::ITEM_IO_LINK:  seg_d = term_word(link_terms_i);
                        dsm_pkg::ITEM_IO_VOLT:  seg_d = hex_word(analog_voltage_input_i);
                        dsm_pkg::ITEM_IO_CURR:  seg_d = hex_word(analog_current_input_i);
                        dsm_pkg::ITEM_IO_METER: seg_d = hex_word(analog_meter_output_i);
                        default:                seg_d = hex_word(16'h0);
                    endcase
                end else if (item == dsm_pkg::ITEM_STATUS) begin
                    seg_d = hex_word(running_status_word_q);
                end else begin
                    seg_d = hex_word(drive_item_value_i);
                end
            end
            default: begin
                seg_d = 32'h0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seg_o <= 32'h0;
        end else begin
            seg_o <= seg_d;
        end
    end
endmodule : dsm_monitor_top
`default_nettype wire

// ---- tb/dsm_monitor_assertions.sv ----
`default_nettype none
module dsm_monitor_assertions (
    input  wire logic                sys_clk_i,
    input  wire logic                rst_n_i,
    input  wire dsm_pkg::dsm_flags_t flags_i,
    input  wire logic [31:0]         seg_o,
    input  wire logic [3:0]          drive_item_sel_o,
    input  wire logic [3:0]          s_awaddr_i,
    input  wire logic                s_awvalid_i,
    input  wire logic                s_awready_o,
    input  wire logic                s_wvalid_i,
    input  wire logic                s_wready_o,
    input  wire logic [1:0]          s_bresp_o,
    input  wire logic                s_bvalid_o,
    input  wire logic                s_bready_i,
    input  wire logic [3:0]          s_araddr_i,
    input  wire logic                s_arvalid_i,
    input  wire logic                s_arready_o,
    input  wire logic [31:0]         s_rdata_o,
    input  wire logic [1:0]          s_rresp_o,
    input  wire logic                s_rvalid_o,
    input  wire logic                s_rready_i
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [15:0] word_exp;
    assign word_exp = {flags_i[11], 2'b00, flags_i[10:5], 1'b0, flags_i[4], 1'b0, flags_i[3:0]};
    sequence s_rd_status;
        s_arvalid_i && s_arready_o && s_araddr_i == dsm_pkg::REG_STATUS;
    endsequence
    sequence s_wr_pair;
        s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o;
    endsequence
    // Flags take one edge into the status register and one more into read data
    a_status_bits: assert property (s_rd_status |=> s_rvalid_o &&
        s_rdata_o == {16'h0000, $past(word_exp, 2)}) else $error("status word mismatch");
    a_reserved_zero: assert property (s_rd_status |=> s_rdata_o[14:13] == 2'b00 &&
        !s_rdata_o[6] && !s_rdata_o[4]) else $error("fixed-zero status bit set");
    a_write_resp: assert property (s_wr_pair |=> s_bvalid_o && s_bresp_o ==
        (($past(s_awaddr_i) == dsm_pkg::REG_CTRL) ? dsm_pkg::RESP_OKAY : dsm_pkg::RESP_SLVERR))
        else $error("write response wrong");
    a_bresp_hold: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o &&
        $stable(s_bresp_o)) else $error("write response dropped early");
    a_rdata_hold: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o &&
        $stable(s_rdata_o) && $stable(s_rresp_o)) else $error("read data dropped early");
    a_read_answer: assert property (s_arvalid_i && s_arready_o |=> s_rvalid_o)
        else $error("read answer late");
    a_write_refuse: assert property (s_bvalid_o |-> !s_awready_o && !s_wready_o)
        else $error("write taken while response pending");
    a_read_refuse: assert property (s_rvalid_o |-> !s_arready_o)
        else $error("read taken while data pending");
    a_reset_blank: assert property ($rose(rst_n_i) |-> seg_o == 32'h0000_0000 &&
        drive_item_sel_o == 4'h0) else $error("outputs not cleared by reset");
endmodule : dsm_monitor_assertions
bind dsm_monitor_top dsm_monitor_assertions u_chk (.*);
`default_nettype wire

// ---- tb/dsm_keypad_model.sv ----
`default_nettype none
module dsm_keypad_model (
    input  wire logic             sys_clk_i,
    output var dsm_pkg::dsm_keys_t keys_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial keys_o = '0;
    task automatic press(input dsm_pkg::dsm_keys_t k);
        @(posedge sys_clk_i);
        keys_o <= k;
        @(posedge sys_clk_i);
        keys_o <= '0;
        repeat (2) @(posedge sys_clk_i);
    endtask : press
endmodule : dsm_keypad_model
`default_nettype wire

// ---- tb/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam dsm_pkg::dsm_keys_t K_UP = 4'h8, K_DN = 4'h4, K_FN = 4'h2, K_BK = 4'h1;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    localparam logic [3:0]  STAT = dsm_pkg::REG_STATUS, CTRL = dsm_pkg::REG_CTRL;
    localparam logic [3:0]  VIEW = dsm_pkg::REG_VIEW, DISP = dsm_pkg::REG_DISPLAY;
    logic                sys_clk_i, rst_n_i, s_awvalid_i, s_wvalid_i, s_bready_i;
    logic                s_arvalid_i, s_rready_i, s_awready_o, s_wready_o, s_bvalid_o;
    logic                s_arready_o, s_rvalid_o;
    logic [3:0]          s_awaddr_i, s_wstrb_i, s_araddr_i, drive_item_sel_o;
    logic [31:0]         s_wdata_i, s_rdata_o, seg_o;
    logic [1:0]          s_bresp_o, s_rresp_o;
    logic [15:0]         drive_item_value_i, analog_voltage_input_i;
    logic [15:0]         analog_current_input_i, analog_meter_output_i;
    dsm_pkg::dsm_flags_t flags_i;
    dsm_pkg::dsm_terms_t terms_i, link_terms_i;
    dsm_pkg::dsm_keys_t  keys_i;
    int                  mismatches = 0;
    int                  num_checks = 0;
    logic [7:0]          glyph [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
                                        8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};

    dsm_keypad_model kp (.sys_clk_i, .keys_o(keys_i));
    dsm_monitor_top DUT (.*);

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [31:0] hex4(input logic [15:0] v);
        return {glyph[v[15:12]], glyph[v[11:8]], glyph[v[7:4]], glyph[v[3:0]]};
    endfunction : hex4
    function automatic logic [15:0] st_word(input dsm_pkg::dsm_flags_t f);
        return {f[11], 2'b00, f[10:5], 1'b0, f[4], 1'b0, f[3:0]};
    endfunction : st_word
    function automatic logic [31:0] term_seg(input dsm_pkg::dsm_terms_t t);
        return {7'h00, t.relay_30, 7'h00, t.y1_out, t.link_cmds, 5'h00, 3'h0, t.din};
    endfunction : term_seg

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        @(posedge sys_clk_i);
        {s_awaddr_i, s_wdata_i} <= {a, d};
        {s_awvalid_i, s_wvalid_i, s_bready_i} <= 3'h7;
        r = 2'h3;
        for (int n = 0; n < 100; n++) begin
            @(negedge sys_clk_i);
            aw_hs = s_awvalid_i && s_awready_o;
            w_hs  = s_wvalid_i && s_wready_o;
            b_hs  = s_bvalid_o && s_bready_i;
            if (b_hs) r = s_bresp_o;
            @(posedge sys_clk_i);
            if (aw_hs) s_awvalid_i <= 1'b0;
            if (w_hs) s_wvalid_i <= 1'b0;
            if (b_hs) begin
                s_bready_i <= 1'b0;
                break;
            end
        end
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        @(posedge sys_clk_i);
        {s_araddr_i, s_arvalid_i, s_rready_i} <= {a, 2'h3};
        {r, d} = {2'h3, 32'h0};
        for (int n = 0; n < 100; n++) begin
            @(negedge sys_clk_i);
            ar_hs = s_arvalid_i && s_arready_o;
            r_hs  = s_rvalid_o && s_rready_i;
            if (r_hs) {d, r} = {s_rdata_o, s_rresp_o};
            @(posedge sys_clk_i);
            if (ar_hs) s_arvalid_i <= 1'b0;
            if (r_hs) begin
                s_rready_i <= 1'b0;
                break;
            end
        end
    endtask : axi_read

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e,
                          input logic [1:0] er = dsm_pkg::RESP_OKAY, input logic [31:0] m = ALL);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        check(d & m, e);
        check({30'h0, r}, {30'h0, er});
    endtask : rd_chk

    task automatic wr_chk(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        axi_write(a, d, r);
        check({30'h0, r}, {30'h0, er});
    endtask : wr_chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        mismatches++;
        $display("mismatch at %0t: run did not finish", $time);
        report_and_stop();
    end

    initial begin
        logic [3:0]          n4;
        logic [31:0]         e;
        dsm_pkg::dsm_flags_t f;
        rst_n_i = 1'b0;
        {s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i} = 5'h00;
        {s_awaddr_i, s_araddr_i, s_wdata_i} = 40'h0;
        s_wstrb_i = 4'hf;
        drive_item_value_i = 16'h5a3c;
        flags_i = '0;
        terms_i = 10'h2d6;
        link_terms_i = 10'h149;
        analog_voltage_input_i = 16'h1234;
        analog_current_input_i = 16'hbcde;
        analog_meter_output_i = 16'h9a0f;
        repeat (12) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rd_chk(CTRL, 32'h0);
        rd_chk(VIEW, 32'h30);
        rd_chk(DISP, 32'hcf00_0000);
        kp.press(K_UP);
        rd_chk(VIEW, 32'h30);
        wr_chk(STAT, ALL, dsm_pkg::RESP_SLVERR);
        rd_chk(4'h6, 32'h0, dsm_pkg::RESP_SLVERR);
        wr_chk(CTRL, {30'h0, dsm_pkg::SCOPE_FULL}, dsm_pkg::RESP_OKAY);
        rd_chk(CTRL, 32'h2);
        kp.press(K_UP);
        rd_chk(VIEW, 32'h40);
        kp.press(K_DN);
        kp.press(K_FN);
        rd_chk(VIEW, 32'h130);
        rd_chk(DISP, 32'h4f08_3f3f);
        repeat (7) kp.press(K_UP);
        kp.press(K_FN);
        rd_chk(VIEW, 32'h237);
        for (int v = 0; v < 16; v++) begin
            n4 = 4'(v);
            f = {n4[0], n4[1], n4, n4[2], n4[3], ~n4};
            flags_i <= f;
            repeat (3) @(posedge sys_clk_i);
            rd_chk(STAT, {16'h0, st_word(f)});
            rd_chk(DISP, hex4(st_word(f)));
        end
        kp.press(K_BK);
        rd_chk(VIEW, 32'h137);
        kp.press(K_UP);
        kp.press(K_FN);
        rd_chk(DISP, hex4(drive_item_value_i));
        check({28'h0, drive_item_sel_o}, 32'h8);
        kp.press(K_BK);
        kp.press(K_BK);
        rd_chk(VIEW, 32'h030, dsm_pkg::RESP_OKAY, 32'h370);
        kp.press(K_UP);
        kp.press(K_FN);
        rd_chk(VIEW, 32'h140);
        for (int i = 0; i < 5; i++) begin
            case (i)
                0: e = term_seg(terms_i);
                1: e = term_seg(link_terms_i);
                2: e = hex4(analog_voltage_input_i);
                3: e = hex4(analog_current_input_i);
                default: e = hex4(analog_meter_output_i);
            endcase
            kp.press(K_FN);
            rd_chk(DISP, e);
            kp.press(K_BK);
            kp.press(K_UP);
        end
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
